// ---- design/wdt_pkg.sv ----
// Watchdog timer: register map, field positions, reset
// values, timing counts, control struct and state codes.
// Assumes a 32-bit APB slave with byte addresses.
package wdt_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INTV = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_CLR = 8'h0c;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_GATE = 8'h14;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTL_TOF = 3;
    localparam int CTL_RCF = 2;
    localparam int CTL_REN = 1;
    localparam int CTL_RWT = 0;
    localparam int INTV_HI = 7;
    localparam int INTV_LO = 6;
    localparam int GATE_EXT = 4;
    localparam int GATE_GLB = 7;
    localparam int ST_TMO = 0;
    localparam int ST_WRST = 1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] INTV_RST = 8'h00;
    localparam logic [7:0] GATE_RST = 8'h00;
    localparam logic [1:0] STAT_RST = 2'h0;

    // ****************************************
    // Timing counts in clocks and machine cycles
    // ****************************************
    localparam int WAIT_CLK = 512;
    localparam int CLK_PER_MC = 4;
    localparam int RST_MC = 2;
    localparam int RST_CLK = CLK_PER_MC * RST_MC;

    // Watchdog control fields
    typedef struct packed {
        logic tof;
        logic rcf;
        logic ren;
        logic restart_bit;
    } wdt_ctl_s;

    // Sequencer states
    typedef enum logic [2:0] {
        S_RUN = 3'b001,
        S_WAIT = 3'b010,
        S_RST = 3'b100
    } wdt_state_e;

endpackage

// ---- design/wdt_top.sv ----
// Watchdog timer with interrupt flag and system reset.
// Assumes an APB master on ref_clk, a timed-access grant
// level from the core, and nrst as power-on/fail reset.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module wdt_top #(
    parameter logic [26:0] INT0 = 27'h002_0000,
    parameter logic [26:0] INT1 = 27'h010_0000,
    parameter logic [26:0] INT2 = 27'h080_0000,
    parameter logic [26:0] INT3 = 27'h400_0000
) (
    // Clock and power-on reset
    input wire logic ref_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core side
    input wire logic taGrant,
    output logic wdtIrq,
    output logic sysRst,
    output logic irq
);

    // ****************************************
    // Declarations
    // ****************************************
    wdt_pkg::wdt_ctl_s ctl_q;
    wdt_pkg::wdt_ctl_s ctl_d;
    wdt_pkg::wdt_state_e st_q;
    wdt_pkg::wdt_state_e st_d;
    logic [7:0] intv_q;
    logic [7:0] gate_q;
    logic [7:0] gate_d;
    logic [1:0] stat_q;
    logic [1:0] stat_d;
    logic [1:0] mask_q;
    logic [1:0] mask_d;
    logic [26:0] cnt_q;
    logic [26:0] cnt_d;
    logic [9:0] wait_q;
    logic [9:0] wait_d;
    logic [2:0] rcnt_q;
    logic [2:0] rcnt_d;
    logic [31:0] prdata_q;
    logic [31:0] rdMux;
    logic pready_q;
    logic pslverr_q;
    logic sysRst_q;
    logic wdtIrq_q;
    logic irq_q;
    logic setup;
    logic wrAcc;
    logic mapped;
    logic wrCtl;
    logic wrProt;
    logic restart;
    logic tmo;
    logic waitDone;
    logic rstDone;
    logic rstStart;
    logic [26:0] limit;
    logic [1:0] sel;

    // ****************************************
    // APB decode
    // ****************************************
    // Setup phase, access write and address hits
    assign setup = psel & ~penable;
    assign wrAcc = psel & penable & pwrite & pready_q;
    assign mapped = paddr == wdt_pkg::OFF_CTRL
        || paddr == wdt_pkg::OFF_INTV
        || paddr == wdt_pkg::OFF_STAT
        || paddr == wdt_pkg::OFF_CLR
        || paddr == wdt_pkg::OFF_MASK
        || paddr == wdt_pkg::OFF_GATE;
    assign wrCtl = wrAcc & (paddr == wdt_pkg::OFF_CTRL);
    assign wrProt = wrCtl & taGrant;

    // Read data selection, taken in the setup phase
    assign rdMux =
        paddr == wdt_pkg::OFF_CTRL ? {28'h0, ctl_q} :
        paddr == wdt_pkg::OFF_INTV ? {24'h0, intv_q} :
        paddr == wdt_pkg::OFF_STAT ? {30'h0, stat_q} :
        paddr == wdt_pkg::OFF_MASK ? {30'h0, mask_q} :
        paddr == wdt_pkg::OFF_GATE ? {24'h0, gate_q} :
        32'h0;

    // Bus answer registers, no wait states
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup) begin
                prdata_q <= rdMux;
            end
        end
    end

    // ****************************************
    // Interval counter
    // ****************************************
    // interval selection
    assign sel = {intv_q[wdt_pkg::INTV_HI],
        intv_q[wdt_pkg::INTV_LO]};
    assign limit = sel == 2'h0 ? INT0 :
        sel == 2'h1 ? INT1 :
        sel == 2'h2 ? INT2 : INT3;
    assign restart = wrProt & pwdata[wdt_pkg::CTL_RWT];
    // every completed interval is a timeout
    assign tmo = (st_q != wdt_pkg::S_RST)
        & (cnt_q == limit - 27'h1);
    // counter runs whatever the reset enable
    assign cnt_d = (restart | tmo | rstStart
        | st_q == wdt_pkg::S_RST) ? 27'h0 : cnt_q + 27'h1;

    // Free-running divider
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 27'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ****************************************
    // Reset sequencer
    // ****************************************
    assign waitDone = wait_q == 10'(wdt_pkg::WAIT_CLK - 1);
    assign rstDone = rcnt_q == 3'(wdt_pkg::RST_CLK - 1);
    assign wait_d = st_q == wdt_pkg::S_WAIT
        ? wait_q + 10'h1 : 10'h0;
    assign rcnt_d = st_q == wdt_pkg::S_RST
        ? rcnt_q + 3'h1 : 3'h0;
    assign rstStart = st_q == wdt_pkg::S_WAIT
        && st_d == wdt_pkg::S_RST;

    // Next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            wdt_pkg::S_RUN: begin
                if (tmo && !restart) begin
                    st_d = wdt_pkg::S_WAIT;
                end
            end
            wdt_pkg::S_WAIT: begin
                if (restart) begin
                    st_d = wdt_pkg::S_RUN;
                end else if (waitDone) begin
                    st_d = ctl_q.ren ? wdt_pkg::S_RST
                        : wdt_pkg::S_RUN;
                end
            end
            wdt_pkg::S_RST: begin
                if (rstDone) begin
                    st_d = wdt_pkg::S_RUN;
                end
            end
            default: st_d = wdt_pkg::S_RUN;
        endcase
    end

    // Sequencer and counters
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= wdt_pkg::S_RUN;
            wait_q <= 10'h0;
            rcnt_q <= 3'h0;
            sysRst_q <= 1'b0;
        end else begin
            st_q <= st_d;
            wait_q <= wait_d;
            rcnt_q <= rcnt_d;
            sysRst_q <= st_d == wdt_pkg::S_RST;
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    // Flag updates; hardware sets win over clears
    always_comb begin
        ctl_d = ctl_q;
        if (wrProt) begin
            ctl_d.tof = pwdata[wdt_pkg::CTL_TOF];
            ctl_d.ren = pwdata[wdt_pkg::CTL_REN];
        end
        if (wrCtl && !pwdata[wdt_pkg::CTL_RCF]) begin
            ctl_d.rcf = 1'b0;
        end
        if (rstStart) begin
            ctl_d.tof = 1'b0;
        end
        if (tmo) begin
            ctl_d.tof = 1'b1;
        end
        // cause only set by an enabled reset
        if (rstStart) begin
            ctl_d.rcf = 1'b1;
        end
        ctl_d.restart_bit = restart;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctl_q <= wdt_pkg::wdt_ctl_s'(wdt_pkg::CTRL_RST[3:0]);
        end else begin
            ctl_q <= ctl_d;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            intv_q <= wdt_pkg::INTV_RST;
            gate_q <= wdt_pkg::GATE_RST;
            mask_q <= 2'h0;
        end else if (wrAcc) begin
            if (paddr == wdt_pkg::OFF_INTV) begin
                intv_q <= pwdata[7:0];
            end
            if (paddr == wdt_pkg::OFF_GATE) begin
                gate_q <= pwdata[7:0];
            end
            if (paddr == wdt_pkg::OFF_MASK) begin
                mask_q <= pwdata[1:0];
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    // Sticky status, write-one-to-clear, set wins
    assign stat_d = (stat_q & ~((wrAcc
        && paddr == wdt_pkg::OFF_CLR) ? pwdata[1:0] : 2'h0))
        | {rstStart, tmo};

    // Next mask and gate, so requests follow a write at once
    assign mask_d = (wrAcc && paddr == wdt_pkg::OFF_MASK)
        ? pwdata[1:0] : mask_q;
    assign gate_d = (wrAcc && paddr == wdt_pkg::OFF_GATE)
        ? pwdata[7:0] : gate_q;

    // Status and interrupt outputs
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stat_q <= wdt_pkg::STAT_RST;
            irq_q <= 1'b0;
            wdtIrq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_d);
            wdtIrq_q <= ctl_d.tof & gate_d[wdt_pkg::GATE_EXT]
                & gate_d[wdt_pkg::GATE_GLB];
        end
    end

    // Outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign sysRst = sysRst_q;
    assign wdtIrq = wdtIrq_q;
    assign irq = irq_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence rstHold;
        sysRst_q [*8] ##1 !sysRst_q;
    endsequence

    sequence graceRun;
        (!sysRst_q && !rstStart) [*8];
    endsequence

    // Timeout ends the interval at the selected length
    intv_len_a: assert property (
        tmo |-> cnt_q == limit - 27'h1 ##1 cnt_q == 27'h0)
        else $error("interval length wrong");

    // Flag follows each timeout
    flag_set_a: assert property (
        tmo |=> ctl_q.tof && stat_q[wdt_pkg::ST_TMO])
        else $error("timeout flag not set");

    // Reset after the grace period
    grace_rst_a: assert property (
        (st_q == wdt_pkg::S_WAIT && waitDone && ctl_q.ren
        && !restart) |=> sysRst_q && ctl_q.rcf)
        else $error("missing watchdog reset");

    // Reset pulse is eight clocks long
    rst_len_a: assert property (
        $rose(sysRst_q) |-> rstHold)
        else $error("reset length wrong");

    // Interrupt request gating
    irq_gate_a: assert property (
        wdtIrq_q |-> ctl_q.tof && gate_q[wdt_pkg::GATE_EXT]
        && gate_q[wdt_pkg::GATE_GLB])
        else $error("interrupt without enables");

    // Restart clears the divider and self-clears
    restart_clr_a: assert property (
        restart |=> cnt_q == 27'h0 && ctl_q.restart_bit
        ##1 !ctl_q.restart_bit || $past(restart))
        else $error("restart not applied");

    // Watchdog reset keeps the enable
    wd_keep_a: assert property (
        $rose(sysRst_q) |-> ctl_q.ren && cnt_q == 27'h0)
        else $error("watchdog reset disabled timer");

    // Cause flag only through an enabled reset
    cause_src_a: assert property (
        $rose(ctl_q.rcf) |-> $past(ctl_q.ren)
        && $past(st_q) == wdt_pkg::S_WAIT)
        else $error("cause flag set while disabled");

    // No reset while the enable is off
    no_reset_a: assert property (
        (!ctl_q.ren && st_q == wdt_pkg::S_WAIT)
        |=> st_q != wdt_pkg::S_RST)
        else $error("reset while disabled");

    // Ungranted writes leave protected bits
    ta_guard_a: assert property (
        (wrCtl && !taGrant && !rstStart) |=> $stable(ctl_q.ren))
        else $error("unguarded protected write");

    // Grace period holds no reset for its first clocks
    grace_min_a: assert property (
        (st_q == wdt_pkg::S_RUN && tmo && !restart)
        |=> st_q == wdt_pkg::S_WAIT ##0 graceRun)
        else $error("reset too early");

endmodule // wdt_top

// ---- tb/wdt_top_test.sv ----
// Self-checking bench for the watchdog block over APB.
// Assumes the design package is compiled first; short
// interval parameters stand in for the long counts.
`timescale 1ns/1ps

module wdt_top_test;
    logic ref_clk, nrst, psel, penable, pwrite, taGrant;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, wdtIrq, sysRst, irq, rstSeen;
    int errors, samplesChecked, n, m;
    int lim[4] = '{68, 128, 256, 512};

    // ****************************************
    // Design under test
    // ****************************************
    // Shortest interval is kept off a divisor of the grace period
    wdt_top #(.INT0(27'h000_0044), .INT1(27'h000_0080),
        .INT2(27'h000_0100), .INT3(27'h000_0200)) wdt_top_inst (
        .ref_clk(ref_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .taGrant(taGrant), .wdtIrq(wdtIrq),
        .sysRst(sysRst), .irq(irq));

    // Clock of 50 ns
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Remembers any watchdog reset pulse
    always @(posedge ref_clk) begin
        if (!nrst) begin
            rstSeen <= 1'b0;
        end else if (sysRst === 1'b1) begin
            rstSeen <= 1'b1;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Waits for the slave; only the 60000-clock time limit ends a hang
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Value compare
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samplesChecked++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Cycle count compare
    task automatic chkn(input string nm, input int lo, input int hi,
        input int g);
        samplesChecked++;
        if (g < lo || g > hi) begin
            errors++;
            $display("wrong value %s expected %0d..%0d seen %0d",
                nm, lo, hi, g);
        end
    endtask

    // Read a register and compare the masked bits
    task automatic rdc(input string nm, input logic [7:0] a,
        input logic [31:0] e, input logic [31:0] msk);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd & msk);
    endtask

    // Counts edges until wdtIrq, or sysRst if rstSel, goes high
    task automatic wait_hi(input bit rstSel, output int c);
        c = 0;
        while ((rstSel ? sysRst : wdtIrq) !== 1'b1 && c < 5000) begin
            @(posedge ref_clk);
            c++;
        end
        if (c >= 5000) begin
            chkn("wait", 0, 4999, c);
        end
    endtask

    task automatic complete_run();
        if (errors == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        repeat (60000) @(posedge ref_clk);
        errors++;
        complete_run();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {nrst, psel, penable, pwrite, taGrant} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        errors = 0;
        samplesChecked = 0;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rdc("ctrl", 8'h00, 32'h0, 32'hff);
        rdc("intv", 8'h04, 32'h0, 32'hff);
        rdc("gate", 8'h14, 32'h0, 32'hff);
        rdc("stat", 8'h08, 32'h0, 32'hff);
        rdc("unmapped", 8'h18, 32'h0, 32'hffff_ffff);
        chk("slverr", 32'h1, {31'h0, err});
        // Protected write without grant is dropped
        wr(8'h00, 32'h0000_000a);
        rdc("ctrl nogrant", 8'h00, 32'h0, 32'hff);
        taGrant <= 1'b1;
        wr(8'h14, 32'h0000_0090);
        for (int s = 0; s < 4; s++) begin
            wr(8'h04, 32'(s) << 6);
            rdc("intv", 8'h04, 32'(s) << 6, 32'hc0);
            wr(8'h00, 32'h0000_0001);
            wait_hi(1'b0, n);
            chkn("interval", lim[s] - 2, lim[s] + 4, n);
            rdc("flag", 8'h00, 32'h8, 32'h9);
            wr(8'h00, 32'h0000_0000);
        end
        wr(8'h04, 32'h0000_0000);
        // Interrupt needs both enables
        for (int g = 0; g < 2; g++) begin
            wr(8'h14, g ? 32'h0000_0080 : 32'h0000_0010);
            wr(8'h0c, 32'h0000_0001);
            wr(8'h00, 32'h0000_0001);
            repeat (80) @(posedge ref_clk);
            chk("wdtIrq gated", 32'h0, {31'h0, wdtIrq});
            rdc("stat tmo", 8'h08, 32'h1, 32'h1);
            wr(8'h0c, 32'h0000_0001);
        end
        // Status, mask and clear
        wr(8'h10, 32'h0000_0001);
        wr(8'h00, 32'h0000_0001);
        repeat (70) @(posedge ref_clk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h10, 32'h0000_0000);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h10, 32'h0000_0001);
        wr(8'h0c, 32'h0000_0001);
        rdc("stat clr", 8'h08, 32'h0, 32'h1);
        chk("irq clr", 32'h0, {31'h0, irq});
        // Reset disabled: flag repeats, no reset, no cause
        wr(8'h14, 32'h0000_0090);
        wr(8'h00, 32'h0000_0001);
        wait_hi(1'b0, n);
        wr(8'h00, 32'h0000_0000);
        repeat (640) @(posedge ref_clk);
        rdc("ctrl again", 8'h00, 32'h8, 32'hf);
        chk("no reset", 32'h0, {31'h0, rstSeen});
        // Restart inside the grace period
        wr(8'h04, 32'h0000_00c0);
        wr(8'h00, 32'h0000_0003);
        wait_hi(1'b0, n);
        repeat (200) @(posedge ref_clk);
        wr(8'h00, 32'h0000_0003);
        rdc("restart clr", 8'h00, 32'h0, 32'h1);
        repeat (600) @(posedge ref_clk);
        chk("grace restart", 32'h0, {31'h0, rstSeen});
        // Missed restart gives a watchdog reset
        wr(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_0003);
        wait_hi(1'b0, n);
        wait_hi(1'b1, n);
        chkn("grace", 505, 515, n);
        m = 0;
        do begin
            m++;
            @(posedge ref_clk);
        end while (sysRst === 1'b1 && m < 50);
        chkn("hold", 8, 8, m);
        rdc("cause", 8'h00, 32'h6, 32'hf);
        rdc("stat wrst", 8'h08, 32'h2, 32'h2);
        wait_hi(1'b0, n);
        chkn("restarted", 55, 70, n);
        wr(8'h00, 32'h0000_0006);
        rdc("cause kept", 8'h00, 32'h6, 32'h6);
        // Power reset in mid-run
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rdc("ctrl por", 8'h00, 32'h0, 32'hff);
        complete_run();
    end
endmodule // wdt_top_test
